/* core/sdram_pwr_ctrl.sv */
// controller end: power-up sequence and self refresh entry and exit
`timescale 1ns/1ps
`default_nettype none
module sdram_pwr_ctrl #(
    parameter int unsigned POWERUP_CYC  = sdram_pwr_pkg::POWERUP_CYCLES,
    parameter int unsigned BURST_REFS   = sdram_pwr_pkg::BURST_REFRESHES,
    parameter logic [11:0] MODE_WORD    = sdram_pwr_pkg::MODE_WORD_DEFAULT
) (
    // clock and reset
    input  wire logic   CLK_SYS,
    input  wire logic   RST,
    input  wire logic   CE,
    // user control
    input  wire logic   SELFREF_REQ,
    input  wire logic   BURST_REFRESH_EN,
    output logic        READY,
    output logic        IN_SELFREF,
    // memory pins
    sdram_pwr_if.ctrl   mem
);
    initial begin
        if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << sdram_pwr_pkg::CNT_W)) $error("bad POWERUP_CYC");
        if (BURST_REFS < 1 || BURST_REFS >= (1 << sdram_pwr_pkg::CNT_W)) $error("bad BURST_REFS");
        if (sdram_pwr_pkg::PRECHARGE_CYCLES >= (1 << sdram_pwr_pkg::CNT_W))
            $error("bad precharge count");
        if (sdram_pwr_pkg::ROW_ACTIVE_CYCLES >= (1 << sdram_pwr_pkg::CNT_W))
            $error("bad row active count");
        if (sdram_pwr_pkg::ROW_CYCLE_CYCLES >= (1 << sdram_pwr_pkg::CNT_W))
            $error("bad row cycle count");
        if (sdram_pwr_pkg::CLOCK_SETTLE_CYCLES >= (1 << sdram_pwr_pkg::CNT_W))
            $error("bad settle count");
        if (sdram_pwr_pkg::MODE_SET_CYCLE_TIME < 2)
            $error("mode set gap too short");
        if (sdram_pwr_pkg::DUMMY_REFRESHES < 2)
            $error("too few dummy refreshes");
    end

    typedef enum logic [3:0] {
        S_WAIT = 4'h0, S_PRE = 4'h1, S_MRS = 4'h3, S_INIT_REF = 4'h2,
        S_IDLE = 4'h6, S_PRE_SR = 4'h7, S_SR_REF = 4'h5, S_SR = 4'h4,
        S_CLK_UP = 4'hC, S_EXIT = 4'hD, S_POST_REF = 4'hF
    } state_t;

    state_t                         state, next_state;
    logic [sdram_pwr_pkg::CNT_W-1:0] cnt, next_cnt;
    logic [sdram_pwr_pkg::CNT_W-1:0] refs, next_refs;
    logic                           cke, next_cke;
    sdram_pwr_pkg::cmd_t            cmd, next_cmd;
    logic                           a10, next_a10;
    logic [11:0]                    addr, next_addr;
    logic                           clk_run, next_clk_run;
    logic [sdram_pwr_pkg::CNT_W-1:0] ref_target;

    assign ref_target = BURST_REFRESH_EN ? sdram_pwr_pkg::CNT_W'(BURST_REFS)
                                         : sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::DUMMY_REFRESHES);

    always_comb begin
        next_state   = state;
        next_cnt     = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_refs    = refs;
        next_cke     = cke;
        next_cmd     = sdram_pwr_pkg::CMD_NOP;
        next_a10     = 1'b0;
        next_addr    = '0;
        next_clk_run = clk_run;
        unique case (state)
            S_WAIT: begin
                if (cnt == '0) begin
                    next_cmd   = sdram_pwr_pkg::CMD_PRECHARGE;
                    next_a10   = 1'b1;
                    next_cnt   = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::PRECHARGE_CYCLES);
                    next_state = S_PRE;
                end
            end
            S_PRE: begin
                if (cnt == '0) begin
                    next_cmd   = sdram_pwr_pkg::CMD_MODE_SET;
                    next_addr  = MODE_WORD;
                    next_cnt   = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::MODE_SET_CYCLE_TIME);
                    next_refs  = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::DUMMY_REFRESHES);
                    next_state = S_MRS;
                end
            end
            S_MRS: begin
                if (cnt == '0) begin
                    next_state = S_INIT_REF;
                end
            end
            S_INIT_REF, S_SR_REF, S_POST_REF: begin
                if (cnt == '0) begin
                    if (refs != '0) begin
                        next_cmd  = sdram_pwr_pkg::CMD_REFRESH;
                        next_refs = refs - 1'b1;
                        next_cnt  = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::ROW_CYCLE_CYCLES);
                    end else if (state == S_SR_REF) begin
                        next_cmd   = sdram_pwr_pkg::CMD_REFRESH;
                        next_cke   = 1'b0;
                        next_cnt   = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::ROW_ACTIVE_CYCLES);
                        next_state = S_SR;
                    end else begin
                        next_state = S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                if (SELFREF_REQ) begin
                    next_cmd   = sdram_pwr_pkg::CMD_PRECHARGE;
                    next_a10   = 1'b1;
                    next_cnt   = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::PRECHARGE_CYCLES);
                    next_state = S_PRE_SR;
                end
            end
            S_PRE_SR: begin
                if (cnt == '0) begin
                    next_refs  = BURST_REFRESH_EN ? ref_target : '0;
                    next_state = S_SR_REF;
                end
            end
            S_SR: begin
                next_clk_run = 1'b0;
                if (cnt == '0 && !SELFREF_REQ) begin
                    next_clk_run = 1'b1;
                    next_cnt     = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::CLOCK_SETTLE_CYCLES);
                    next_state   = S_CLK_UP;
                end
            end
            S_CLK_UP: begin
                if (cnt == '0) begin
                    next_cke   = 1'b1;
                    next_cmd   = sdram_pwr_pkg::CMD_DESELECT;
                    next_cnt   = sdram_pwr_pkg::CNT_W'(sdram_pwr_pkg::ROW_CYCLE_CYCLES);
                    next_state = S_EXIT;
                end
            end
            S_EXIT: begin
                next_cmd = sdram_pwr_pkg::CMD_DESELECT;
                if (cnt == '0) begin
                    next_refs  = BURST_REFRESH_EN ? ref_target : '0;
                    next_state = S_POST_REF;
                end
            end
            default: next_state = S_WAIT;
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= S_WAIT;
            cnt   <= sdram_pwr_pkg::CNT_W'(POWERUP_CYC);
            refs  <= '0;
        end else if (CE) begin
            state <= next_state;
            cnt   <= next_cnt;
            refs  <= next_refs;
        end
    end

    // command pin registers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cke     <= 1'b1;
            cmd     <= sdram_pwr_pkg::CMD_NOP;
            a10     <= 1'b0;
            addr    <= '0;
            clk_run <= 1'b1;
        end else if (CE) begin
            cke     <= next_cke;
            cmd     <= next_cmd;
            a10     <= next_a10;
            addr    <= next_addr;
            clk_run <= next_clk_run;
        end
    end

    // status and mask registers, taken from the next state
    logic [3:0] dqm, next_dqm;
    logic       ready, next_ready;
    logic       in_sr, next_in_sr;

    always_comb begin
        next_dqm   = (next_state == S_WAIT || next_state == S_PRE) ? 4'hF : 4'h0;
        next_ready = (next_state == S_IDLE);
        next_in_sr = (next_state == S_SR);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            dqm   <= 4'hF;
            ready <= 1'b0;
            in_sr <= 1'b0;
        end else if (CE) begin
            dqm   <= next_dqm;
            ready <= next_ready;
            in_sr <= next_in_sr;
        end
    end

    assign mem.cke     = cke;
    assign mem.cmd     = cmd;
    assign mem.a10     = a10;
    assign mem.addr    = addr;
    assign mem.dqm     = dqm;
    assign mem.clk_run = clk_run;
    assign READY       = ready;
    assign IN_SELFREF  = in_sr;
endmodule
`default_nettype wire

/* core/sdram_pwr_if.sv */
// command pins between controller and memory ends
`timescale 1ns/1ps
`default_nettype none
interface sdram_pwr_if;
    logic        cke;
    logic [3:0]  cmd;
    logic        a10;
    logic [11:0] addr;
    logic [3:0]  dqm;
    logic        clk_run;
    modport ctrl (output cke, output cmd, output a10, output addr, output dqm, output clk_run);
    modport mem  (input cke, input cmd, input a10, input addr, input dqm, input clk_run);
endinterface
`default_nettype wire

/* core/sdram_pwr_mem.sv */
// memory end: self refresh state and clock-enable suspension
`timescale 1ns/1ps
`default_nettype none
module sdram_pwr_mem (
    // clock and reset
    input  wire logic   CLK_SYS,
    input  wire logic   RST,
    input  wire logic   CE,
    // memory pins
    sdram_pwr_if.mem    pins,
    // array side
    output logic        SELF_REFRESHING,
    output logic        INT_CLK_EN,
    output logic        MODE_LOADED,
    output logic [11:0] MODE_WORD
);
    typedef enum logic [1:0] {M_NORMAL = 2'h0, M_SR = 2'h1} mstate_t;

    mstate_t     state, next_state;
    logic        cke_q, next_cke_q;
    logic        int_en, next_int_en;
    logic        loaded, next_loaded;
    logic [11:0] mode, next_mode;
    logic        sr_entry;

    assign sr_entry = !pins.cke && pins.cmd == sdram_pwr_pkg::CMD_REFRESH;

    always_comb begin
        next_state  = state;
        next_cke_q  = pins.cke;
        next_int_en = int_en;
        next_loaded = loaded;
        next_mode   = mode;
        unique case (state)
            M_NORMAL: begin
                if (cke_q && sr_entry) begin
                    next_state  = M_SR;
                    next_int_en = 1'b0;
                end else begin
                    next_int_en = pins.cke;
                    if (pins.cke && cke_q && pins.cmd == sdram_pwr_pkg::CMD_MODE_SET) begin
                        next_loaded = 1'b1;
                        next_mode   = pins.addr;
                    end
                end
            end
            M_SR: begin
                next_int_en = 1'b0;
                if (pins.cke) begin
                    next_state  = M_NORMAL;
                    next_int_en = 1'b1;
                end
            end
            default: next_state = M_NORMAL;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state  <= M_NORMAL;
            cke_q  <= 1'b1;
            int_en <= 1'b1;
            loaded <= 1'b0;
            mode   <= '0;
        end else if (CE) begin
            state  <= next_state;
            cke_q  <= next_cke_q;
            int_en <= next_int_en;
            loaded <= next_loaded;
            mode   <= next_mode;
        end
    end

    assign SELF_REFRESHING = (state == M_SR);
    assign INT_CLK_EN      = int_en;
    assign MODE_LOADED     = loaded;
    assign MODE_WORD       = mode;
endmodule
`default_nettype wire

/* core/sdram_pwr_pkg.sv */
// constants and types shared by the controller and memory ends
// How it works
// - controller holds nop, cke and mask high
// - controller waits 200 us after power-up
// - controller keeps byte masks high while waiting
// - controller precharges all banks before mode set
// - controller issues one mode register set
// - controller issues at least two dummy refreshes
// - self refresh: cs, ras, cas low, cke low
// - one clock after entry only cke matters
// - memory stays in self refresh while cke low
// - controller holds self refresh at least row-active time
// - controller has clock stable before raising cke
// - on exit cke high for exit setup, cs high
// - controller waits one row cycle after exit
// - burst refresh: 2048 refreshes around self refresh
// - cke suspends internal clock one cycle later
// - controller waits two clocks after mode set
package sdram_pwr_pkg;
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned POWERUP_WAIT_US = 200;
    localparam int unsigned POWERUP_CYCLES = (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ROW_ACTIVE_NS = 45;
    localparam int unsigned ROW_ACTIVE_CYCLES = (ROW_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ROW_CYCLE_NS = 70;
    localparam int unsigned ROW_CYCLE_CYCLES = (ROW_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned PRECHARGE_NS = 20;
    localparam int unsigned PRECHARGE_CYCLES = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SELFREF_EXIT_SETUP_TIME_CYCLES = 1;
    localparam int unsigned MODE_SET_CYCLE_TIME = 2;
    localparam int unsigned DUMMY_REFRESHES = 2;
    localparam int unsigned BURST_REFRESHES = 2048;
    localparam int unsigned CLOCK_SETTLE_CYCLES = 8;
    localparam logic [11:0] MODE_WORD_DEFAULT = 12'h0_022;
    localparam int unsigned CNT_W = 16;
    // {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_NOP       = 4'h7,
        CMD_PRECHARGE = 4'h2,
        CMD_REFRESH   = 4'h1,
        CMD_MODE_SET  = 4'h0,
        CMD_DESELECT  = 4'hF
    } cmd_t;
endpackage

/* dv/sdram_init_selfrefresh_ctrl_bench.sv */
// testbench joining the controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module sdram_init_selfrefresh_ctrl_bench;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        sr_req = 1'b0;
    logic        burst_en = 1'b0;
    logic        ready, in_sr, self_ref, int_clk_en, mode_loaded;
    logic [11:0] mode_word;
    logic [3:0]  log_q[$];
    int          err_total = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          since = 0;
    int          refs = 0;
    int          first_cmd = -1;
    sdram_pwr_if u_sdram_pwr_if ();
    sdram_pwr_ctrl #(.POWERUP_CYC(20), .BURST_REFS(4)) u_sdram_pwr_ctrl (.CLK_SYS(clk_sys),
        .RST(rst), .CE(ce), .SELFREF_REQ(sr_req), .BURST_REFRESH_EN(burst_en), .READY(ready),
        .IN_SELFREF(in_sr), .mem(u_sdram_pwr_if));
    sdram_pwr_mem u_sdram_pwr_mem (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .pins(u_sdram_pwr_if),
        .SELF_REFRESHING(self_ref), .INT_CLK_EN(int_clk_en), .MODE_LOADED(mode_loaded),
        .MODE_WORD(mode_word));
    sdram_pwr_checker #(.POWERUP_CYC(20)) u_sdram_pwr_checker (.CLK_SYS(clk_sys), .RST(rst),
        .cke(u_sdram_pwr_if.cke), .cmd(u_sdram_pwr_if.cmd), .a10(u_sdram_pwr_if.a10),
        .dqm(u_sdram_pwr_if.dqm), .clk_run(u_sdram_pwr_if.clk_run));
    always #5 clk_sys = ~clk_sys;
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // command log and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        since <= rst ? 0 : since + 1;
        if (!rst && u_sdram_pwr_if.cke && u_sdram_pwr_if.cmd[3] === 1'b0
            && u_sdram_pwr_if.cmd !== 4'h7) begin
            log_q.push_back(u_sdram_pwr_if.cmd);
            if (u_sdram_pwr_if.cmd === 4'h1) refs = refs + 1;
            if (first_cmd < 0) first_cmd = since;
        end
        if (cyc == 6000) begin
            err_total++;
            final_report();
        end
    end
    task automatic check_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? ready : (w == 1) ? in_sr : u_sdram_pwr_if.cke;
    endfunction
    task automatic wait_sig(input int w, input logic lvl);
        int n;
        n = 0;
        while (pick(w) !== lvl && n < 800) begin
            @(negedge clk_sys);
            n++;
        end
        check_val("wait level", lvl, pick(w));
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        log_q.delete();
        refs = 0;
        first_cmd = -1;
    endtask
    initial begin
        @(negedge clk_sys);
        do_reset();
        check_val("cke", 1'b1, u_sdram_pwr_if.cke);
        check_val("cmd", 4'h7, u_sdram_pwr_if.cmd);
        check_val("dqm", 4'hF, u_sdram_pwr_if.dqm);
        wait_sig(0, 1'b1);
        check_val("first cmd late", 1'b1, first_cmd >= 19);
        check_val("first cmd", 4'h2, log_q[0]);
        check_val("second cmd", 4'h0, log_q[1]);
        check_val("init refreshes", 2, refs);
        check_val("mode loaded", 1'b1, mode_loaded);
        check_val("mode word", 12'h0_022, mode_word);
        for (int b = 0; b < 2; b++) begin
            burst_en = b[0];
            refs = 0;
            sr_req = 1'b1;
            wait_sig(2, 1'b0);
            check_val("int clk at entry", 1'b1, int_clk_en);
            @(negedge clk_sys);
            check_val("int clk stopped", 1'b0, int_clk_en);
            check_val("self refreshing", 1'b1, self_ref);
            check_val("burst refs before", 1'b1, b == 0 || refs == 4);
            ce = 1'b0;
            repeat (3) @(negedge clk_sys);
            ce = 1'b1;
            repeat (10) @(negedge clk_sys);
            check_val("held", 1'b1, self_ref);
            check_val("clock stopped", 1'b0, u_sdram_pwr_if.clk_run);
            refs = 0;
            sr_req = 1'b0;
            wait_sig(2, 1'b1);
            @(negedge clk_sys);
            check_val("left self refresh", 1'b0, self_ref);
            check_val("int clk back", 1'b1, int_clk_en);
            wait_sig(0, 1'b1);
            check_val("burst refs after", 1'b1, b == 0 || refs == 4);
        end
        sr_req = 1'b1;
        wait_sig(2, 1'b0);
        sr_req = 1'b0;
        do_reset();
        check_val("cke after reset", 1'b1, u_sdram_pwr_if.cke);
        wait_sig(0, 1'b1);
        check_val("re-init refreshes", 2, refs);
        final_report();
    end
endmodule
`default_nettype wire

/* dv/sdram_pwr_checker.sv */
// assertions on the command pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module sdram_pwr_checker #(
    parameter int unsigned POWERUP_CYC = 20
) (
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RST,
    // memory pins
    input wire logic       cke,
    input wire logic [3:0] cmd,
    input wire logic       a10,
    input wire logic [3:0] dqm,
    input wire logic       clk_run
);
    logic [15:0] cyc;
    logic [15:0] next_cyc;
    logic        pre_seen;
    logic        next_pre_seen;
    always_comb begin
        next_cyc = (cyc == 16'hFFFF) ? cyc : cyc + 16'h0001;
        next_pre_seen = pre_seen | (cmd == 4'h2);
    end
    always_ff @(posedge CLK_SYS) begin
        cyc <= RST ? 16'h0000 : next_cyc;
        pre_seen <= RST ? 1'b0 : next_pre_seen;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    chk_reset_idle: assert property (disable iff (1'b0)
        RST |=> cke && cmd == 4'h7 && dqm == 4'hF) else $error("pins not idle after reset");
    chk_powerup_wait: assert property (
        cyc < POWERUP_CYC - 1 |-> cmd == 4'h7) else $error("command during power-up wait");
    chk_wait_mask: assert property (
        cyc < POWERUP_CYC - 1 |-> dqm == 4'hF) else $error("mask low during power-up wait");
    chk_pre_all: assert property (
        cmd == 4'h2 |-> a10) else $error("precharge not for all banks");
    chk_pre_first: assert property (
        cmd == 4'h0 |-> pre_seen) else $error("mode set before precharge");
    chk_mode_gap: assert property (
        cmd == 4'h0 |=> (cmd == 4'h7 || cmd == 4'hF) [*2]) else $error("command too soon after mode set");
    chk_sr_entry: assert property (
        $fell(cke) |-> cmd == 4'h1) else $error("cke fell without self refresh command");
    chk_sr_hold: assert property (
        $fell(cke) |=> !cke [*5]) else $error("self refresh left too early");
    chk_clk_settle: assert property (
        $rose(cke) |-> clk_run && $past(clk_run, 4)) else $error("cke rose before clock settled");
    chk_exit_deselect: assert property (
        $rose(cke) |-> cmd[3] ##1 cke) else $error("exit without deselect");
    chk_exit_rc: assert property (
        $rose(cke) |-> (cmd == 4'h7 || cmd == 4'hF) [*7]) else $error("command before row cycle");
    chk_clk_stop: assert property (
        !clk_run |-> !cke) else $error("clock stopped outside self refresh");
endmodule
`default_nettype wire
